// file: rtl/brp_regs.svh
`ifndef BRP_REGS_SVH
`define BRP_REGS_SVH
`define BRP_ADDR_CTRL 8'h00
`define BRP_ADDR_STATUS 8'h04
`define BRP_ADDR_PF_BASE 8'h08
`define BRP_ADDR_PF_LIMIT 8'h0C
`define BRP_CTRL_NOPRED 2
`define BRP_CTRL_CFGCONV 3
`define BRP_CTRL_MRM_LSB 4
`define BRP_CTRL_MRL_LSB 6
`define BRP_CTRL_MR_LSB 8
`define BRP_CTRL_MASK 32'h0000_03FC
`define BRP_CTRL_RESET 32'h0000_0000
`define BRP_PF_BASE_RESET 32'h0000_0000
`define BRP_PF_LIMIT_RESET 32'h0000_0000
`define BRP_DISCARD_CYC 32'h0000_8000
`endif

// file: rtl/brp_pkg.sv
`default_nettype none
package brp_pkg;
  typedef enum logic [3:0] {
    BRP_CMD_MR = 4'h6,
    BRP_CMD_CFGRD = 4'hA,
    BRP_CMD_CFGWR = 4'hB,
    BRP_CMD_MRM = 4'hC,
    BRP_CMD_MRL = 4'hE,
    BRP_CMD_OTHER = 4'h0
  } brp_cmd_t;

  typedef enum logic [1:0] {
    BRP_LEN_REQ = 2'b00,
    BRP_LEN_LINE = 2'b01,
    BRP_LEN_FULL = 2'b10
  } brp_len_t;

  typedef struct packed {
    logic aw_have;
    logic [7:0] aw_addr;
    logic w_have;
    logic [31:0] w_data;
    logic [3:0] w_strb;
    logic awready;
    logic wready;
    logic bvalid;
    logic [1:0] bresp;
    logic arready;
    logic rvalid;
    logic [31:0] rdata;
    logic [1:0] rresp;
  } brp_axi_st_t;

  typedef struct packed {
    logic [31:0] count;
    logic expire;
  } brp_tmr_st_t;

  typedef struct packed {
    logic [31:0] ctrl;
    logic [31:0] pf_base;
    logic [31:0] pf_limit;
    logic retained;
    logic [31:0] ret_addr;
    logic [3:0] last_cmd;
    logic last_full;
    logic fetch_valid;
    brp_len_t fetch_len;
    logic fetch_pred;
    logic fetch_type1;
    logic [31:0] fetch_addr;
    logic hit;
  } brp_top_st_t;
endpackage : brp_pkg
`default_nettype wire

// file: rtl/brp_if.sv
`default_nettype none
interface brp_reg_if;
  logic wr_en;
  logic [7:0] wr_addr;
  logic [31:0] wr_data;
  logic [3:0] wr_strb;
  logic wr_ok;
  logic [7:0] rd_addr;
  logic [31:0] rd_data;
  logic rd_ok;
  modport slv (output wr_en, wr_addr, wr_data, wr_strb, rd_addr, input wr_ok, rd_data, rd_ok);
  modport regs (input wr_en, wr_addr, wr_data, wr_strb, rd_addr, output wr_ok, rd_data, rd_ok);
endinterface : brp_reg_if

interface brp_tmr_if;
  logic load;
  logic expire;
  modport tmr (input load, output expire);
  modport user (output load, input expire);
endinterface : brp_tmr_if
`default_nettype wire

// file: rtl/brp_timer.sv
`default_nettype none
module brp_timer
  import brp_pkg::*;
#(
  parameter logic [31:0] CYCLES = 32'h0000_8000
) (
  input wire logic clk,
  input wire logic rstn,
  brp_tmr_if.tmr t
);
  brp_tmr_st_t q;
  brp_tmr_st_t n;

  // A load restarts the count; the expiry pulse comes CYCLES edges after the load.
  always_comb begin
    n = q;
    n.expire = 1'b0;
    if (t.load) begin
      n.count = CYCLES;
    end else if (q.count != 32'h0000_0000) begin
      n.count = q.count - 32'h0000_0001;
      n.expire = (q.count == 32'h0000_0001);
    end
  end

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign t.expire = q.expire;
endmodule : brp_timer
`default_nettype wire

// file: rtl/brp_axil.sv
`default_nettype none
module brp_axil
  import brp_pkg::*;
(
  input wire logic clk,
  input wire logic rstn,
  input wire logic [7:0] awaddr,
  input wire logic awvalid,
  output logic awready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  input wire logic wvalid,
  output logic wready,
  output logic [1:0] bresp,
  output logic bvalid,
  input wire logic bready,
  input wire logic [7:0] araddr,
  input wire logic arvalid,
  output logic arready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  output logic rvalid,
  input wire logic rready,
  brp_reg_if.slv r
);
  brp_axi_st_t q;
  brp_axi_st_t n;

  // Address and data are held separately, so either may arrive first.
  always_comb begin
    n = q;
    r.wr_en = 1'b0;
    if (awvalid && q.awready) begin
      n.aw_have = 1'b1;
      n.aw_addr = awaddr;
    end
    if (wvalid && q.wready) begin
      n.w_have = 1'b1;
      n.w_data = wdata;
      n.w_strb = wstrb;
    end
    if (q.bvalid && bready) begin
      n.bvalid = 1'b0;
    end
    if (n.aw_have && n.w_have && !n.bvalid) begin
      r.wr_en = 1'b1;
      n.bvalid = 1'b1;
      n.bresp = r.wr_ok ? 2'b00 : 2'b10;
      n.aw_have = 1'b0;
      n.w_have = 1'b0;
    end
    n.awready = !n.aw_have && !n.bvalid;
    n.wready = !n.w_have && !n.bvalid;
    if (q.rvalid && rready) begin
      n.rvalid = 1'b0;
    end
    if (arvalid && q.arready) begin
      n.rvalid = 1'b1;
      n.rdata = r.rd_data;
      n.rresp = r.rd_ok ? 2'b00 : 2'b10;
    end
    n.arready = !n.rvalid;
  end

  assign r.wr_addr = (awvalid && q.awready) ? awaddr : q.aw_addr;
  assign r.wr_data = (wvalid && q.wready) ? wdata : q.w_data;
  assign r.wr_strb = (wvalid && q.wready) ? wstrb : q.w_strb;
  assign r.rd_addr = araddr;

  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      q <= '0;
    end else begin
      q <= n;
    end
  end

  assign awready = q.awready;
  assign wready = q.wready;
  assign bvalid = q.bvalid;
  assign bresp = q.bresp;
  assign arready = q.arready;
  assign rvalid = q.rvalid;
  assign rdata = q.rdata;
  assign rresp = q.rresp;
endmodule : brp_axil
`default_nettype wire

// file: rtl/brp_top.sv
`include "brp_regs.svh"
`default_nettype none
module brp_top
  import brp_pkg::*;
#(
  parameter logic [31:0] DISCARD_CYCLES = `BRP_DISCARD_CYC
) (
  input wire logic SYS_CLK,
  input wire logic RSTN,
  input wire logic [7:0] S_AXI_AWADDR,
  input wire logic S_AXI_AWVALID,
  output logic S_AXI_AWREADY,
  input wire logic [31:0] S_AXI_WDATA,
  input wire logic [3:0] S_AXI_WSTRB,
  input wire logic S_AXI_WVALID,
  output logic S_AXI_WREADY,
  output logic [1:0] S_AXI_BRESP,
  output logic S_AXI_BVALID,
  input wire logic S_AXI_BREADY,
  input wire logic [7:0] S_AXI_ARADDR,
  input wire logic S_AXI_ARVALID,
  output logic S_AXI_ARREADY,
  output logic [31:0] S_AXI_RDATA,
  output logic [1:0] S_AXI_RRESP,
  output logic S_AXI_RVALID,
  input wire logic S_AXI_RREADY,
  input wire logic REQ_VALID,
  input wire logic [3:0] REQ_CMD,
  input wire logic [31:0] REQ_ADDR,
  input wire logic END_VALID,
  input wire logic END_BY_BRIDGE,
  input wire logic [31:0] END_ADDR,
  output logic FETCH_VALID,
  output logic [1:0] FETCH_LEN,
  output logic FETCH_PREDICT,
  output logic FETCH_TYPE1,
  output logic [31:0] FETCH_ADDR,
  output logic HIT,
  output logic RETAINED
);
  brp_top_st_t q;
  brp_top_st_t n;
  brp_reg_if r ();
  brp_tmr_if t ();
  brp_cmd_t cmd;
  logic in_pref;
  logic is_mem;
  logic is_hit;
  logic [1:0] mrm_f;
  logic [1:0] mrl_f;
  logic [1:0] mr_f;
  logic keep;

  brp_axil u_axil (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .awaddr(S_AXI_AWADDR),
    .awvalid(S_AXI_AWVALID),
    .awready(S_AXI_AWREADY),
    .wdata(S_AXI_WDATA),
    .wstrb(S_AXI_WSTRB),
    .wvalid(S_AXI_WVALID),
    .wready(S_AXI_WREADY),
    .bresp(S_AXI_BRESP),
    .bvalid(S_AXI_BVALID),
    .bready(S_AXI_BREADY),
    .araddr(S_AXI_ARADDR),
    .arvalid(S_AXI_ARVALID),
    .arready(S_AXI_ARREADY),
    .rdata(S_AXI_RDATA),
    .rresp(S_AXI_RRESP),
    .rvalid(S_AXI_RVALID),
    .rready(S_AXI_RREADY),
    .r(r.slv)
  );

  brp_timer #(.CYCLES(DISCARD_CYCLES)) u_timer (
    .clk(SYS_CLK),
    .rstn(RSTN),
    .t(t.tmr)
  );

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] wd,
                                        input logic [3:0] be);
    logic [31:0] res;
    res = old;
    for (int i = 0; i < 4; i++) begin
      if (be[i]) begin
        res[i*8 +: 8] = wd[i*8 +: 8];
      end
    end
    return res;
  endfunction : merge

  assign cmd = brp_cmd_t'(REQ_CMD);
  assign mrm_f = q.ctrl[`BRP_CTRL_MRM_LSB +: 2];
  assign mrl_f = q.ctrl[`BRP_CTRL_MRL_LSB +: 2];
  assign mr_f = q.ctrl[`BRP_CTRL_MR_LSB +: 2];
  assign in_pref = (REQ_ADDR >= q.pf_base) && (REQ_ADDR <= q.pf_limit);
  assign is_mem = (cmd == BRP_CMD_MR) || (cmd == BRP_CMD_MRL) || (cmd == BRP_CMD_MRM);
  assign is_hit = q.retained && (REQ_ADDR == q.ret_addr);

  // Register read decode.
  always_comb begin
    r.rd_ok = 1'b1;
    r.wr_ok = 1'b1;
    case (r.rd_addr[7:2])
      6'h00: r.rd_data = q.ctrl;
      6'h01: r.rd_data = {24'h00_0000, q.last_cmd, 2'b00, q.last_full, q.retained};
      6'h02: r.rd_data = q.pf_base;
      6'h03: r.rd_data = q.pf_limit;
      default: begin
        r.rd_data = 32'h0000_0000;
        r.rd_ok = 1'b0;
      end
    endcase
    if (r.wr_addr[7:2] > 6'h03) begin
      r.wr_ok = 1'b0;
    end
  end

  // Leftover data is kept only when the fetch was full and the policy matches who ended it.
  always_comb begin
    keep = 1'b0;
    if (q.last_full) begin
      case (q.last_cmd)
        BRP_CMD_MRM: keep = (mrm_f == 2'b11) || ((mrm_f == 2'b01) && END_BY_BRIDGE);
        BRP_CMD_MRL: begin
          keep = (mrl_f == 2'b11) || ((mrl_f == 2'b01) && !END_BY_BRIDGE);
        end
        default: keep = 1'b0;
      endcase
    end
  end

  always_comb begin
    n = q;
    t.load = 1'b0;
    n.fetch_valid = 1'b0;
    n.hit = 1'b0;
    if (r.wr_en) begin
      case (r.wr_addr[7:2])
        6'h00: n.ctrl = merge(q.ctrl, r.wr_data, r.wr_strb) & `BRP_CTRL_MASK;
        6'h02: n.pf_base = merge(q.pf_base, r.wr_data, r.wr_strb);
        6'h03: n.pf_limit = merge(q.pf_limit, r.wr_data, r.wr_strb);
        default: n.ctrl = q.ctrl;
      endcase
    end
    if (t.expire) begin
      n.retained = 1'b0;
    end
    if (END_VALID) begin
      if (keep) begin
        n.retained = 1'b1;
        n.ret_addr = END_ADDR;
        t.load = 1'b1;
      end
      n.last_full = 1'b0;
    end
    if (REQ_VALID) begin
      if ((cmd == BRP_CMD_CFGRD) || (cmd == BRP_CMD_CFGWR)) begin
        n.fetch_valid = 1'b1;
        n.fetch_len = BRP_LEN_REQ;
        n.fetch_pred = 1'b0;
        n.fetch_addr = REQ_ADDR;
        n.fetch_type1 = REQ_ADDR[0];
        if (q.ctrl[`BRP_CTRL_CFGCONV] && (REQ_ADDR[31:28] == 4'hF)) begin
          n.fetch_type1 = 1'b1;
          n.fetch_addr = {REQ_ADDR[31:1], 1'b1};
        end
      end else if (is_mem && is_hit) begin
        n.hit = 1'b1;
        n.retained = 1'b0;
      end else if (is_mem) begin
        n.retained = 1'b0;
        n.fetch_valid = 1'b1;
        n.fetch_addr = REQ_ADDR;
        n.fetch_type1 = 1'b0;
        n.fetch_pred = !q.ctrl[`BRP_CTRL_NOPRED];
        n.fetch_len = BRP_LEN_REQ;
        if (in_pref) begin
          case (cmd)
            BRP_CMD_MRM: n.fetch_len = (mrm_f == 2'b00) ? BRP_LEN_LINE : BRP_LEN_FULL;
            BRP_CMD_MRL: n.fetch_len = (mrl_f == 2'b00) ? BRP_LEN_LINE : BRP_LEN_FULL;
            default: n.fetch_len = mr_f[1] ? BRP_LEN_FULL : BRP_LEN_LINE;
          endcase
        end
        n.last_cmd = REQ_CMD;
        n.last_full = (n.fetch_len == BRP_LEN_FULL);
      end
    end
  end

  always_ff @(posedge SYS_CLK or negedge RSTN) begin
    if (!RSTN) begin
      q <= '0;
      q.ctrl <= `BRP_CTRL_RESET;
      q.pf_base <= `BRP_PF_BASE_RESET;
      q.pf_limit <= `BRP_PF_LIMIT_RESET;
    end else begin
      q <= n;
    end
  end

  assign FETCH_VALID = q.fetch_valid;
  assign FETCH_LEN = q.fetch_len;
  assign FETCH_PREDICT = q.fetch_pred;
  assign FETCH_TYPE1 = q.fetch_type1;
  assign FETCH_ADDR = q.fetch_addr;
  assign HIT = q.hit;
  assign RETAINED = q.retained;

  default clocking cb @(posedge SYS_CLK);
  endclocking
  default disable iff (!RSTN);

  logic mem_new;
  assign mem_new = REQ_VALID && is_mem && !is_hit;

  predict_on_a: assert property (
    mem_new && !q.ctrl[`BRP_CTRL_NOPRED]
    |=> FETCH_VALID && FETCH_PREDICT)
    else $error("prediction missing");
  predict_off_a: assert property (
    mem_new && q.ctrl[`BRP_CTRL_NOPRED]
    |=> !FETCH_PREDICT)
    else $error("prediction not disabled");
  cfg_convert_a: assert property (
    REQ_VALID && (cmd == BRP_CMD_CFGRD) && q.ctrl[`BRP_CTRL_CFGCONV]
    && REQ_ADDR[31:28] == 4'hF |=> FETCH_TYPE1 && FETCH_ADDR[0])
    else $error("type 0 not converted");
  cfg_noconv_a: assert property (
    REQ_VALID && (cmd == BRP_CMD_CFGRD) && !q.ctrl[`BRP_CTRL_CFGCONV]
    && REQ_ADDR[1:0] == 2'b00 |=> !FETCH_TYPE1)
    else $error("conversion while disabled");
  mrm_line_a: assert property (
    mem_new && cmd == BRP_CMD_MRM && in_pref && mrm_f == 2'b00
    |=> FETCH_LEN == BRP_LEN_LINE)
    else $error("read multiple not one line");
  mrm_full_a: assert property (
    mem_new && cmd == BRP_CMD_MRM && in_pref && mrm_f != 2'b00
    |=> FETCH_LEN == BRP_LEN_FULL)
    else $error("read multiple not full");
  mrl_line_a: assert property (
    mem_new && cmd == BRP_CMD_MRL && in_pref && mrl_f == 2'b00
    |=> FETCH_LEN == BRP_LEN_LINE)
    else $error("read line not one line");
  mrl_full_a: assert property (
    mem_new && cmd == BRP_CMD_MRL && in_pref && mrl_f != 2'b00
    |=> FETCH_LEN == BRP_LEN_FULL)
    else $error("read line not full");
  mr_line_a: assert property (
    mem_new && cmd == BRP_CMD_MR && in_pref && mr_f == 2'b00
    |=> FETCH_LEN == BRP_LEN_LINE)
    else $error("memory read not one line");
  mr_full_a: assert property (
    mem_new && cmd == BRP_CMD_MR && in_pref && mr_f[1]
    |=> FETCH_LEN == BRP_LEN_FULL)
    else $error("memory read not full");
  out_range_a: assert property (
    mem_new && !in_pref
    |=> FETCH_VALID && FETCH_LEN == BRP_LEN_REQ)
    else $error("prefetch outside range");
  mrm_bridge_a: assert property (
    END_VALID && !REQ_VALID && q.last_full && q.last_cmd == BRP_CMD_MRM && mrm_f == 2'b01
    && END_BY_BRIDGE |=> RETAINED)
    else $error("bridge disconnect leftover not kept");
  mrm_keep_a: assert property (
    END_VALID && !REQ_VALID && q.last_full && q.last_cmd == BRP_CMD_MRM && mrm_f == 2'b11
    |=> RETAINED)
    else $error("leftover not kept");
  mrl_master_a: assert property (
    END_VALID && !REQ_VALID && q.last_full && q.last_cmd == BRP_CMD_MRL && mrl_f == 2'b01
    && !END_BY_BRIDGE |=> RETAINED)
    else $error("master disconnect leftover not kept");
  mrl_keep_a: assert property (
    END_VALID && !REQ_VALID && q.last_full && q.last_cmd == BRP_CMD_MRL && mrl_f == 2'b11
    |=> RETAINED)
    else $error("read line leftover not kept");
  mrl_drop_a: assert property (
    END_VALID && !REQ_VALID && q.last_cmd == BRP_CMD_MRL && mrl_f == 2'b10 && !RETAINED
    |=> !RETAINED)
    else $error("read line 10 kept data");
  retain_hold_a: assert property (
    RETAINED && !t.expire && !REQ_VALID
    |=> RETAINED)
    else $error("retained data lost before expiry");
  discard_a: assert property (
    t.expire && !END_VALID
    |=> !RETAINED)
    else $error("retained data survived expiry");
endmodule : brp_top
`default_nettype wire

// file: testbench/brp_pci_master.sv
`default_nettype none
module brp_pci_master (
  input wire logic clk,
  output logic req_valid,
  output logic [3:0] req_cmd,
  output logic [31:0] req_addr,
  output logic end_valid,
  output logic end_by_bridge,
  output logic [31:0] end_addr
);
  timeunit 1ns;
  timeprecision 1ps;
  initial begin
    req_valid = 1'b0;
    req_cmd = 4'h0;
    req_addr = 32'h0;
    end_valid = 1'b0;
    end_by_bridge = 1'b0;
    end_addr = 32'h0;
  end
  // Outside the address phase the lines show the inverse of the last value.
  task automatic issue(input logic [3:0] c, input logic [31:0] a);
    @(posedge clk);
    req_valid <= 1'b1;
    req_cmd <= c;
    req_addr <= a;
    @(posedge clk);
    req_valid <= 1'b0;
    req_cmd <= ~c;
    req_addr <= ~a;
  endtask : issue
  task automatic end_xfer(input logic by_br, input logic [31:0] a);
    @(posedge clk);
    end_valid <= 1'b1;
    end_by_bridge <= by_br;
    end_addr <= a;
    @(posedge clk);
    end_valid <= 1'b0;
    end_by_bridge <= ~by_br;
    end_addr <= ~a;
  endtask : end_xfer
endmodule : brp_pci_master
`default_nettype wire

// file: testbench/tb_brp_top.sv
`include "brp_regs.svh"
`default_nettype none
module tb_brp_top
  import brp_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;
  logic clk, rstn, awvalid, wvalid, bready, arvalid, rready;
  logic awready, wready, bvalid, arready, rvalid;
  logic [7:0] awaddr, araddr;
  logic [31:0] wdata, rdata, req_addr, end_addr, fetch_addr;
  logic [3:0] wstrb, req_cmd;
  logic [1:0] bresp, rresp, fetch_len;
  logic req_valid, end_valid, end_by_bridge, fetch_valid;
  logic fetch_predict, fetch_type1, hit, retained;
  int err_count;
  int comparisons;
  brp_top #(.DISCARD_CYCLES(32'h0000_0008)) i_brp_top (.SYS_CLK(clk), .RSTN(rstn),
    .S_AXI_AWADDR(awaddr), .S_AXI_AWVALID(awvalid), .S_AXI_AWREADY(awready),
    .S_AXI_WDATA(wdata), .S_AXI_WSTRB(wstrb), .S_AXI_WVALID(wvalid), .S_AXI_WREADY(wready),
    .S_AXI_BRESP(bresp), .S_AXI_BVALID(bvalid), .S_AXI_BREADY(bready),
    .S_AXI_ARADDR(araddr), .S_AXI_ARVALID(arvalid), .S_AXI_ARREADY(arready),
    .S_AXI_RDATA(rdata), .S_AXI_RRESP(rresp), .S_AXI_RVALID(rvalid), .S_AXI_RREADY(rready),
    .REQ_VALID(req_valid), .REQ_CMD(req_cmd), .REQ_ADDR(req_addr), .END_VALID(end_valid),
    .END_BY_BRIDGE(end_by_bridge), .END_ADDR(end_addr), .FETCH_VALID(fetch_valid),
    .FETCH_LEN(fetch_len), .FETCH_PREDICT(fetch_predict), .FETCH_TYPE1(fetch_type1),
    .FETCH_ADDR(fetch_addr), .HIT(hit), .RETAINED(retained));
  brp_pci_master i_brp_pci_master (.clk(clk), .req_valid(req_valid), .req_cmd(req_cmd),
    .req_addr(req_addr), .end_valid(end_valid), .end_by_bridge(end_by_bridge),
    .end_addr(end_addr));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  task automatic wrap_up();
    if (err_count == 0 && comparisons > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask : wrap_up
  task automatic chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
    comparisons++;
    if (got !== exp) begin
      err_count++;
      $display("wrong value %s expected %h seen %h", nm, exp, got);
    end
  endtask : chk
  task automatic timeout(input logic done);
    if (!done) begin
      err_count++;
      wrap_up();
    end
  endtask : timeout
  task automatic axw(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er);
    logic done, ha, hw;
    logic [1:0] rs;
    @(posedge clk);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    done = 1'b0;
    for (int n = 0; n < 50 && !done; n++) begin
      #1;
      done = bvalid === 1'b1;
      rs = bresp;
      ha = awready === 1'b1;
      hw = wready === 1'b1;
      @(posedge clk);
      if (ha) awvalid <= 1'b0;
      if (hw) wvalid <= 1'b0;
    end
    bready <= 1'b0;
    timeout(done);
    chk("bresp", {30'h0, er}, {30'h0, rs});
  endtask : axw
  task automatic axr(input logic [7:0] a, input logic [31:0] ed, input logic [1:0] er);
    logic done, ha;
    logic [1:0] rs;
    logic [31:0] rd;
    @(posedge clk);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    done = 1'b0;
    for (int n = 0; n < 50 && !done; n++) begin
      #1;
      done = rvalid === 1'b1;
      rs = rresp;
      rd = rdata;
      ha = arready === 1'b1;
      @(posedge clk);
      if (ha) arvalid <= 1'b0;
    end
    rready <= 1'b0;
    timeout(done);
    chk("rdata", ed, rd);
    chk("rresp", {30'h0, er}, {30'h0, rs});
  endtask : axr
  task automatic req(input logic [3:0] c, input logic [31:0] a);
    i_brp_pci_master.issue(c, a);
    #1;
  endtask : req
  task automatic fchk(input logic [1:0] len, input logic pred);
    chk("fetch_valid", 32'h1, {31'h0, fetch_valid});
    chk("fetch_len", {30'h0, len}, {30'h0, fetch_len});
    chk("fetch_predict", {31'h0, pred}, {31'h0, fetch_predict});
  endtask : fchk
  task automatic ret(input logic by_br, input logic exp);
    i_brp_pci_master.end_xfer(by_br, 32'h0000_1340);
    #1;
    chk("retained", {31'h0, exp}, {31'h0, retained});
  endtask : ret
  initial begin
    err_count = 0;
    comparisons = 0;
    rstn = 1'b0;
    {awvalid, wvalid, bready, arvalid, rready} = 5'h00;
    awaddr = 8'h00;
    araddr = 8'h00;
    wdata = 32'h0;
    wstrb = 4'hF;
    repeat (10) @(posedge clk);
    rstn <= 1'b1;
    @(posedge clk);
    axr(`BRP_ADDR_CTRL, `BRP_CTRL_RESET, 2'b00);
    axr(8'h10, 32'h0, 2'b10);
    axw(8'h10, 32'hFFFF_FFFF, 2'b10);
    axw(`BRP_ADDR_CTRL, 32'hFFFF_FFFF, 2'b00);
    axr(`BRP_ADDR_CTRL, `BRP_CTRL_MASK, 2'b00);
    axw(`BRP_ADDR_PF_BASE, 32'h0000_1000, 2'b00);
    axw(`BRP_ADDR_PF_LIMIT, 32'h0000_1FFF, 2'b00);
    for (int f = 0; f < 4; f++) begin
      axw(`BRP_ADDR_CTRL, (f << 8) | (f << 6) | (f << 4) | ((f & 1) << 2), 2'b00);
      req(BRP_CMD_MRM, 32'h0000_1000);
      fchk((f == 0) ? BRP_LEN_LINE : BRP_LEN_FULL, !f[0]);
      chk("fetch_addr", 32'h0000_1000, fetch_addr);
      req(BRP_CMD_MRL, 32'h0000_1004);
      fchk((f == 0) ? BRP_LEN_LINE : BRP_LEN_FULL, !f[0]);
      req(BRP_CMD_MR, 32'h0000_1FFF);
      fchk(f[1] ? BRP_LEN_FULL : BRP_LEN_LINE, !f[0]);
      req(BRP_CMD_MR, 32'h0000_2000);
      fchk(BRP_LEN_REQ, !f[0]);
    end
    axw(`BRP_ADDR_CTRL, 32'h0000_0008, 2'b00);
    req(BRP_CMD_CFGRD, 32'hF000_0A04);
    chk("fetch_type1", 32'h1, {31'h0, fetch_type1});
    chk("fetch_addr", 32'hF000_0A05, fetch_addr);
    req(BRP_CMD_CFGWR, 32'h7000_0A04);
    chk("fetch_type1", 32'h0, {31'h0, fetch_type1});
    axw(`BRP_ADDR_CTRL, 32'h0000_0000, 2'b00);
    req(BRP_CMD_CFGRD, 32'hF000_0A04);
    chk("fetch_type1", 32'h0, {31'h0, fetch_type1});
    axw(`BRP_ADDR_CTRL, 32'h0000_00F0, 2'b00);
    req(BRP_CMD_MRM, 32'h0000_1300);
    ret(1'b0, 1'b1);
    axr(`BRP_ADDR_STATUS, 32'h0000_00C1, 2'b00);
    req(BRP_CMD_MRM, 32'h0000_1340);
    chk("hit", 32'h1, {31'h0, hit});
    chk("fetch_valid", 32'h0, {31'h0, fetch_valid});
    chk("retained", 32'h0, {31'h0, retained});
    req(BRP_CMD_MRL, 32'h0000_1300);
    ret(1'b1, 1'b1);
    repeat (4) @(posedge clk);
    #1;
    chk("retained", 32'h1, {31'h0, retained});
    repeat (8) @(posedge clk);
    #1;
    chk("retained", 32'h0, {31'h0, retained});
    req(BRP_CMD_MRL, 32'h0000_1340);
    chk("fetch_valid", 32'h1, {31'h0, fetch_valid});
    axw(`BRP_ADDR_CTRL, 32'h0000_0050, 2'b00);
    req(BRP_CMD_MRM, 32'h0000_1300);
    ret(1'b0, 1'b0);
    req(BRP_CMD_MRM, 32'h0000_1300);
    ret(1'b1, 1'b1);
    req(BRP_CMD_MRL, 32'h0000_1300);
    ret(1'b1, 1'b0);
    req(BRP_CMD_MRL, 32'h0000_1300);
    ret(1'b0, 1'b1);
    axw(`BRP_ADDR_CTRL, 32'h0000_0080, 2'b00);
    req(BRP_CMD_MRL, 32'h0000_1300);
    ret(1'b0, 1'b0);
    axw(`BRP_ADDR_CTRL, 32'h0000_0300, 2'b00);
    req(BRP_CMD_MR, 32'h0000_1300);
    ret(1'b1, 1'b0);
    wrap_up();
  end
endmodule : tb_brp_top
`default_nettype wire
